/* hw/fhp_defs.svh */
/*
  Constants of the fieldbus host packet port: command codes, packet sizes,
  status bit positions, refresh times and the controller's register map.
  Assumes a 200 MHz system clock shared by both ends.
*/
`ifndef FHP_DEFS_SVH
`define FHP_DEFS_SVH

// ==========================================================================
// Commands and packet sizes
`define FHP_CMD_NULL 8'h00
`define FHP_CMD_MRESET 8'h77
`define FHP_DL_BYTES 4
`define FHP_UL_BYTES 14

// ==========================================================================
// Status word bit positions (first byte holds bits 15..8)
`define FHP_ST_SRC_LO 8
`define FHP_ST_SRC_HI 9
`define FHP_ST_SP_OK 10
`define FHP_ST_TLE 12
`define FHP_ST_TOGGLE 13
`define FHP_ST_BUS_FLT 14
`define FHP_ST_OVT 1
`define FHP_ST_ILK 2
`define FHP_ST_PFAIL 3
`define FHP_ST_CONT 5
`define FHP_ST_OUT_ON 7
`define FHP_SRC_USER 2'h0
`define FHP_SRC_HOST 2'h2

// ==========================================================================
// Timing
`define FHP_CLK_MHZ 200
`define FHP_SLOW_MS 100
`define FHP_FAST_MS 20
`define FHP_STALL_MS 300

// ==========================================================================
// Controller register map (APB byte addresses)
`define FHP_A_CMD 8'h00
`define FHP_A_CTRL 8'h04
`define FHP_A_STAT 8'h08
`define FHP_A_UL0 8'h0C
`define FHP_A_UL1 8'h10
`define FHP_A_UL2 8'h14
`define FHP_A_UL3 8'h18
`define FHP_A_INT_ST 8'h1C
`define FHP_A_INT_EN 8'h20
`define FHP_A_INT_CLR 8'h24
`define FHP_CTRL_SEND 0
`define FHP_INT_UPLOAD 0
`define FHP_INT_STALL 1
`define FHP_INT_FAULT 2
`define FHP_INT_W 3
`define FHP_INT_EN_RST 3'h0
`define FHP_CMD_RST 32'h0000_0000

`endif

/* hw/fhp_pkg.sv */
/*
  Types of the fieldbus host packet port: state records of both ends.
  Assumes fhp_defs.svh on the include path.
*/
`default_nettype none
`include "fhp_defs.svh"

package fhp_pkg;

  // ========================================================================
  // Device end state
  typedef struct packed {
    logic fault;
    logic toggle;
    logic slow_pend;
    logic fast_pend;
    logic [31:0] slow_cnt;
    logic [31:0] fast_cnt;
    logic [8*`FHP_UL_BYTES-1:0] ul;
    logic ul_valid;
    logic cmd_valid;
    logic [7:0] cmd_code;
    logic [23:0] cmd_data;
    logic [7:0] last_cmd;
    logic [7:0] rep_cmd;
    logic [39:0] rep_data;
    logic [8:0] pin_s1;
    logic [8:0] pin_s2;
    logic [8:0] pin_s3;
    logic [8:0] pin_lvl;
  } fhp_dev_st_t;

  // ========================================================================
  // Controller state
  typedef enum logic [1:0] {
    FHP_IDLE,
    FHP_SEND_CMD,
    FHP_WAIT_ACK
  } fhp_seq_t;

  typedef struct packed {
    fhp_seq_t seq;
    logic [31:0] cmd;
    logic dl_valid;
    logic [31:0] dl_data;
    logic [8*`FHP_UL_BYTES-1:0] ul;
    logic last_tog;
    logic [31:0] stall_cnt;
    logic stalled;
    logic fault_seen;
    logic [`FHP_INT_W-1:0] int_st;
    logic [`FHP_INT_W-1:0] int_en;
    logic [31:0] prdata;
    logic pslverr;
  } fhp_host_st_t;

endpackage

`default_nettype wire

/* hw/fhp_link_if.sv */
/*
  Link between the fieldbus master end and the device end: one download
  packet strobe with its four bytes, the fourteen-byte upload image with its
  strobe, the link error event and the latched fault level.
  Assumes both ends run on the same clock.
*/
`default_nettype none
`include "fhp_defs.svh"

interface fhp_link_if;
  logic dl_valid;
  logic [8*`FHP_DL_BYTES-1:0] dl_data;
  logic ul_valid;
  logic [8*`FHP_UL_BYTES-1:0] ul_data;
  logic link_err;
  logic dev_fault;

  modport dev (
    input dl_valid,
    input dl_data,
    input link_err,
    output ul_valid,
    output ul_data,
    output dev_fault
  );

  modport host (
    output dl_valid,
    output dl_data,
    output link_err,
    input ul_valid,
    input ul_data,
    input dev_fault
  );
endinterface

`default_nettype wire

/* hw/fhp_dev.sv */
/*
  Device end of the fieldbus host packet port. Takes download packets,
  hands commands to the generator core, latches link faults and keeps the
  upload image fresh.
  Assumes the master end, the generator core and the power readings share
  clk_i; the plant status flags come from pins and are synchronised here,
  which delays each flag by three to four cycles.
*/
// Register access over APB and the register offsets were chosen for this implementation.
`default_nettype none
`include "fhp_defs.svh"

// Function
// - Link error forces output off, sets fault
// - Faults latched until master reset command 119
// - Command code zero is ignored
// - Master sends null, data, command, then packet
// - Download handled before upload refresh
// - Upload every 100 ms, output-on every 20 ms
// - Download: command byte then three data bytes
// - Download data least significant byte first
// - Fourteen-byte upload: status then three powers
// - Bytes 8-12 data, byte 13 answered command
// - Upload data least significant byte first
// - Bits 9:8 give control source
// - Bit 10 setpoint OK, bit 12 target end
// - Bit 14 reports supply bus fault
// - Second byte: temperature, interlock, power, contactor, output
// - Toggle bit keeps changing while ready
module fhp_dev
  import fhp_pkg::*;
#(
  parameter int unsigned SLOW_CYC = `FHP_SLOW_MS * 1000 * `FHP_CLK_MHZ,
  parameter int unsigned FAST_CYC = `FHP_FAST_MS * 1000 * `FHP_CLK_MHZ
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Fieldbus link
  fhp_link_if.dev link,
  // Measured powers
  input wire logic [15:0] dlv_pwr_i,
  input wire logic [15:0] fwd_pwr_i,
  input wire logic [15:0] rfl_pwr_i,
  // Plant status
  input wire logic host_ctrl_i,
  input wire logic setpoint_ok_i,
  input wire logic target_life_expired_i,
  input wire logic bus_fault_i,
  input wire logic overtemp_i,
  input wire logic interlock_open_i,
  input wire logic power_fail_i,
  input wire logic contactor_open_i,
  input wire logic output_on_i,
  // Commands to the generator core
  output logic cmd_valid_o,
  output logic [7:0] cmd_code_o,
  output logic [23:0] cmd_data_o,
  // Replies from the generator core
  input wire logic reply_valid_i,
  input wire logic [39:0] reply_data_i,
  // Power and fault
  output logic rf_enable_o,
  output logic fault_o
);

  fhp_dev_st_t q, d;
  logic [15:0] st;
  logic [7:0] dl_code;
  logic [8:0] pin_raw;
  logic [8:0] pin_next;
  logic host_ctrl, setpoint_ok, target_life_expired, bus_fault, overtemp;
  logic interlock_open, power_fail, contactor_open, output_on;

  // ========================================================================
  // Plant pins: three flops, a change counts once stages two and three agree
  assign pin_raw = {host_ctrl_i, setpoint_ok_i, target_life_expired_i, bus_fault_i, overtemp_i,
    interlock_open_i, power_fail_i, contactor_open_i, output_on_i};

  generate
    for (genvar k = 0; k < 9; k++) begin : g_pin
      // A single odd sample never reaches the upload image
      assign pin_next[k] = (q.pin_s2[k] == q.pin_s3[k]) ? q.pin_s2[k] : q.pin_lvl[k];
    end
  endgenerate

  // Synchronised levels
  assign host_ctrl = q.pin_lvl[8];
  assign setpoint_ok = q.pin_lvl[7];
  assign target_life_expired = q.pin_lvl[6];
  assign bus_fault = q.pin_lvl[5];
  assign overtemp = q.pin_lvl[4];
  assign interlock_open = q.pin_lvl[3];
  assign power_fail = q.pin_lvl[2];
  assign contactor_open = q.pin_lvl[1];
  assign output_on = q.pin_lvl[0];

  // ========================================================================
  // Status word
  always_comb begin
    // Reserved bits stay zero from the all-zero start
    st = 16'h0000;
    st[`FHP_ST_SRC_HI:`FHP_ST_SRC_LO] = host_ctrl ? `FHP_SRC_HOST : `FHP_SRC_USER;
    st[`FHP_ST_SP_OK] = setpoint_ok;
    st[`FHP_ST_TLE] = target_life_expired;
    st[`FHP_ST_TOGGLE] = ~q.toggle;
    st[`FHP_ST_BUS_FLT] = bus_fault;
    st[`FHP_ST_OVT] = overtemp;
    st[`FHP_ST_ILK] = interlock_open;
    st[`FHP_ST_PFAIL] = power_fail;
    st[`FHP_ST_CONT] = contactor_open;
    st[`FHP_ST_OUT_ON] = output_on;
  end

  assign dl_code = link.dl_data[7:0];

  // ========================================================================
  // Next state
  always_comb begin
    d = q;
    d.cmd_valid = 1'b0;
    d.ul_valid = 1'b0;

    // Pin stages
    d.pin_s1 = pin_raw;
    d.pin_s2 = q.pin_s1;
    d.pin_s3 = q.pin_s2;
    d.pin_lvl = pin_next;

    // Refresh timers run free; one due during a download waits a cycle
    if (q.slow_cnt >= SLOW_CYC - 1) begin
      d.slow_cnt = 32'h0000_0000;
      d.slow_pend = 1'b1;
    end else begin
      d.slow_cnt = q.slow_cnt + 32'h0000_0001;
    end
    if (q.fast_cnt >= FAST_CYC - 1) begin
      d.fast_cnt = 32'h0000_0000;
      d.fast_pend = 1'b1;
    end else begin
      d.fast_cnt = q.fast_cnt + 32'h0000_0001;
    end

    // Reply from the core fills the data field
    if (reply_valid_i) begin
      d.rep_data = reply_data_i;
      d.rep_cmd = q.last_cmd;
    end

    if (link.dl_valid) begin
      // Every exchange answers with the upload image
      d.ul_valid = 1'b1;
      if (dl_code == `FHP_CMD_NULL) begin
        d.fault = q.fault;
      end else if (dl_code == `FHP_CMD_MRESET) begin
        d.fault = 1'b0;
      end else begin
        // Passed on at once, refresh waits a cycle
        d.cmd_valid = 1'b1;
        d.cmd_code = dl_code;
        d.cmd_data = link.dl_data[31:8];
        d.last_cmd = dl_code;
      end
    end else if (q.slow_pend) begin
      // Full refresh; byte k sits at bits 8k+7..8k
      d.ul = {q.rep_cmd, q.rep_data, rfl_pwr_i, fwd_pwr_i, dlv_pwr_i, st[7:0], st[15:8]};
      d.toggle = ~q.toggle;
      d.slow_pend = 1'b0;
      d.fast_pend = 1'b0;
    end else if (q.fast_pend) begin
      // Only the output-on flag tracks the fast rate
      d.ul[8 + `FHP_ST_OUT_ON] = output_on;
      d.fast_pend = 1'b0;
    end

    // Error set wins over a master reset in the same cycle
    if (link.link_err) begin
      d.fault = 1'b1;
    end
  end

  // ========================================================================
  // State register
  // Image holds zero from reset; before the first full refresh only fast refreshes write its output-on bit
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ========================================================================
  // Outputs
  assign link.ul_valid = q.ul_valid;
  assign link.ul_data = q.ul;
  assign link.dev_fault = q.fault;
  // Code and data hold until the next command
  assign cmd_valid_o = q.cmd_valid;
  assign cmd_code_o = q.cmd_code;
  assign cmd_data_o = q.cmd_data;
  // Output held off for as long as the fault stands
  assign rf_enable_o = ~q.fault;
  assign fault_o = q.fault;

endmodule

`default_nettype wire

/* hw/fhp_host.sv */
/*
  Master end of the fieldbus host packet port. Software writes a command
  over APB; the end sends a null packet, then the real one, captures each
  upload and watches the toggle bit.
  Assumes the device end shares clk_i.
*/
`default_nettype none
`include "fhp_defs.svh"

module fhp_host
  import fhp_pkg::*;
#(
  parameter int unsigned STALL_CYC = `FHP_STALL_MS * 1000 * `FHP_CLK_MHZ
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic pready_o,
  output logic [31:0] prdata_o,
  output logic pslverr_o,
  // Physical layer error event
  input wire logic phy_err_i,
  // Interrupt
  output logic irq_o,
  // Fieldbus link
  fhp_link_if.host link
);

  fhp_host_st_t q, d;
  logic setup, acc_wr;
  logic [`FHP_INT_W-1:0] ev, clr;

  assign setup = psel_i & ~penable_i;
  assign acc_wr = psel_i & penable_i & pwrite_i;

  always_comb begin
    d = q;
    d.dl_valid = 1'b0;
    ev = '0;
    clr = '0;

    // ======================================================================
    // APB read data is prepared in the setup cycle
    if (setup) begin
      d.pslverr = 1'b0;
      case (paddr_i)
        `FHP_A_CMD: d.prdata = q.cmd;
        `FHP_A_STAT: d.prdata = {29'h0, q.stalled, link.dev_fault, q.seq != FHP_IDLE};
        `FHP_A_UL0: d.prdata = q.ul[31:0];
        `FHP_A_UL1: d.prdata = q.ul[63:32];
        `FHP_A_UL2: d.prdata = q.ul[95:64];
        `FHP_A_UL3: d.prdata = {16'h0, q.ul[111:96]};
        `FHP_A_INT_ST: d.prdata = {29'h0, q.int_st};
        `FHP_A_INT_EN: d.prdata = {29'h0, q.int_en};
        `FHP_A_CTRL, `FHP_A_INT_CLR: d.prdata = 32'h0000_0000;
        default: begin
          d.prdata = 32'h0000_0000;
          d.pslverr = 1'b1;
        end
      endcase
    end

    // ======================================================================
    // Packet sequence: null first so stale data never executes
    case (q.seq)
      FHP_IDLE: begin
        if (acc_wr && paddr_i == `FHP_A_CTRL && pwdata_i[`FHP_CTRL_SEND]) begin
          d.dl_valid = 1'b1;
          d.dl_data = {24'h0, `FHP_CMD_NULL};
          d.seq = FHP_SEND_CMD;
        end
      end
      FHP_SEND_CMD: begin
        if (link.ul_valid) begin
          d.dl_valid = 1'b1;
          d.dl_data = q.cmd;
          d.seq = FHP_WAIT_ACK;
        end
      end
      FHP_WAIT_ACK: begin
        if (link.ul_valid) begin
          d.seq = FHP_IDLE;
        end
      end
      default: d.seq = FHP_IDLE;
    endcase

    if (acc_wr) begin
      case (paddr_i)
        // Command held while a send is under way
        `FHP_A_CMD: d.cmd = (q.seq == FHP_IDLE) ? pwdata_i : q.cmd;
        `FHP_A_INT_EN: d.int_en = pwdata_i[`FHP_INT_W-1:0];
        `FHP_A_INT_CLR: clr = pwdata_i[`FHP_INT_W-1:0];
        default: d.int_en = q.int_en;
      endcase
    end

    // ======================================================================
    // Upload capture and liveness watch
    if (link.ul_valid) begin
      d.ul = link.ul_data;
      ev[`FHP_INT_UPLOAD] = 1'b1;
    end
    if (link.ul_data[`FHP_ST_TOGGLE - 8] != q.last_tog) begin
      d.last_tog = link.ul_data[`FHP_ST_TOGGLE - 8];
      d.stall_cnt = 32'h0000_0000;
      d.stalled = 1'b0;
    end else if (q.stall_cnt >= STALL_CYC - 1) begin
      d.stalled = 1'b1;
      ev[`FHP_INT_STALL] = ~q.stalled;
    end else begin
      d.stall_cnt = q.stall_cnt + 32'h0000_0001;
    end
    d.fault_seen = link.dev_fault;
    ev[`FHP_INT_FAULT] = link.dev_fault & ~q.fault_seen;

    // Event set wins over a clear in the same cycle
    d.int_st = (q.int_st & ~clr) | ev;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q <= '0;
      q.cmd <= `FHP_CMD_RST;
      q.int_en <= `FHP_INT_EN_RST;
    end else begin
      q <= d;
    end
  end

  assign pready_o = psel_i & penable_i;
  assign prdata_o = q.prdata;
  assign pslverr_o = q.pslverr & psel_i & penable_i;
  assign irq_o = |(q.int_st & q.int_en);
  assign link.dl_valid = q.dl_valid;
  assign link.dl_data = q.dl_data;
  assign link.link_err = phy_err_i;

endmodule

`default_nettype wire

/* test/fhp_link_sva.sv */
/*
  Link checker: packet timing, fault latch, status bits, toggle.
  Assumes one clock for both ends; sits beside the link.
*/
`default_nettype none
module fhp_link_sva #(
  parameter int unsigned SLOW_CYC = 200
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Link
  input wire logic dl_valid,
  input wire logic [31:0] dl_data,
  input wire logic ul_valid,
  input wire logic [111:0] ul_data,
  input wire logic link_err,
  input wire logic dev_fault
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Toggle age, slack for a deferred refresh
  logic tog_q;
  logic [31:0] age_q;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tog_q <= 1'h0;
      age_q <= 32'h0;
    end else begin
      tog_q <= ul_data[5];
      age_q <= (ul_data[5] != tog_q) ? 32'h0 : age_q + 32'h1;
    end
  end
  // ==========
  // Properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_null;
    dl_valid && dl_data[7:0] == 8'h00;
  endsequence
  sequence s_mreset;
    dl_valid && dl_data[7:0] == 8'h77 && !link_err;
  endsequence
  a_ul_answer: assert property (dl_valid |=> ul_valid) else $error("no upload");
  a_ul_cause: assert property (ul_valid |-> $past(dl_valid)) else $error("stray upload");
  a_cmd_after_null: assert property (dl_valid && dl_data[7:0] != 8'h00 |-> $past(dl_valid, 2) &&
    ($past(dl_data, 2) & 32'hFF) == 32'h0) else $error("no null first");
  a_err_fault: assert property (link_err |=> dev_fault) else $error("fault not set");
  a_fault_cause: assert property ($rose(dev_fault) |-> $past(link_err)) else $error("fault no cause");
  a_fault_clear: assert property (dev_fault ##0 s_mreset |=> !dev_fault) else $error("fault kept");
  a_null_keeps: assert property (dev_fault ##0 s_null |=> dev_fault) else $error("null cleared");
  a_fault_hold: assert property (dev_fault && !(dl_valid && dl_data[7:0] == 8'h77) |=> dev_fault)
    else $error("fault dropped");
  a_src_code: assert property (ul_data[0] == 1'h0) else $error("bad source");
  a_resv_zero: assert property (ul_data[3] == 1'h0 && ul_data[7] == 1'h0 && ul_data[8] == 1'h0 &&
    ul_data[12] == 1'h0 && ul_data[14] == 1'h0) else $error("reserved set");
  a_toggle_live: assert property (age_q <= SLOW_CYC + 4) else $error("toggle stuck");
endmodule
`default_nettype wire

/* test/fhp_bench.sv */
/*
  Bench for both ends of the packet port.
  Assumes 200 MHz clock; short refresh counts.
*/
`default_nettype none
`include "fhp_defs.svh"
module fhp_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned SLOW = 200;
  typedef struct packed {
    logic [8:0] f;
    logic [15:0] p;
    logic [15:0] st;
  } fhp_row_t;
  fhp_row_t rows [4] = '{'{9'h100, 16'h1234, 16'h0200}, '{9'h0E0, 16'hABCD, 16'h5400},
    '{9'h01E, 16'h00FF, 16'h002E}, '{9'h001, 16'hFF00, 16'h0080}};
  logic clk_i, rstn_i, psel, penable, pwrite, pready, pslverr, phy_err, irq, cmd_valid, rf_en, fault, rvalid, err;
  logic [7:0] paddr, cmd_code, code_seen;
  logic [31:0] pwdata, prdata, rd;
  logic [23:0] cmd_data, data_seen;
  logic [39:0] rdata;
  logic [8:0] flags;
  logic [15:0] pwr;
  int fails = 0, num_checks = 0, ncmd = 0, n0;
  // ==========
  // Design
  fhp_link_if fhp_link_if_inst ();
  fhp_dev #(.SLOW_CYC(SLOW), .FAST_CYC(40)) fhp_dev_inst (.clk_i(clk_i), .rstn_i(rstn_i),
    .link(fhp_link_if_inst.dev), .dlv_pwr_i(pwr), .fwd_pwr_i(~pwr), .rfl_pwr_i(pwr ^ 16'h0F0F),
    .host_ctrl_i(flags[8]), .setpoint_ok_i(flags[7]), .target_life_expired_i(flags[6]), .bus_fault_i(flags[5]),
    .overtemp_i(flags[4]), .interlock_open_i(flags[3]), .power_fail_i(flags[2]), .contactor_open_i(flags[1]),
    .output_on_i(flags[0]), .cmd_valid_o(cmd_valid), .cmd_code_o(cmd_code), .cmd_data_o(cmd_data),
    .reply_valid_i(rvalid), .reply_data_i(rdata), .rf_enable_o(rf_en), .fault_o(fault));
  fhp_host #(.STALL_CYC(1000)) fhp_host_inst (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
    .prdata_o(prdata), .pslverr_o(pslverr), .phy_err_i(phy_err), .irq_o(irq), .link(fhp_link_if_inst.host));
  fhp_link_sva #(.SLOW_CYC(SLOW)) fhp_link_sva_inst (.clk_i(clk_i), .rstn_i(rstn_i),
    .dl_valid(fhp_link_if_inst.dl_valid), .dl_data(fhp_link_if_inst.dl_data), .ul_valid(fhp_link_if_inst.ul_valid),
    .ul_data(fhp_link_if_inst.ul_data), .link_err(fhp_link_if_inst.link_err), .dev_fault(fhp_link_if_inst.dev_fault));
  initial begin
    clk_i = 1'h0;
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (cmd_valid === 1'h1) begin
      ncmd++;
      code_seen = cmd_code;
      data_seen = cmd_data;
    end
  end
  // ==========
  // Tasks
  task check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Waits on pready for up to 20 cycles, then fails the bench
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) begin
      fails++;
      give_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task send(input logic [31:0] c);
    int n;
    apb(1'h1, `FHP_A_CMD, c);
    apb(1'h1, `FHP_A_CTRL, 32'h1);
    n = 0;
    do begin
      apb(1'h0, `FHP_A_STAT, 32'h0);
      n++;
    end while (rd[0] !== 1'h0 && n < 50);
    if (n >= 50) begin
      fails++;
      give_verdict();
    end
  endtask
  // ==========
  // Sequence
  initial begin
    rstn_i = 1'h0;
    {psel, penable, pwrite, phy_err, rvalid} = 5'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    rdata = 40'h0;
    flags = 9'h0;
    pwr = 16'h0;
    repeat (5) @(posedge clk_i);
    rstn_i <= 1'h1;
    for (int i = 0; i < 4; i++) begin
      flags <= rows[i].f;
      pwr <= rows[i].p;
      send({8'h30, 8'h20, 8'h10 + 8'(i), 8'h08});
      check(code_seen, 8'h08);
      check(data_seen, {8'h30, 8'h20, 8'h10 + 8'(i)});
      @(posedge clk_i);
      rvalid <= 1'h1;
      rdata <= {8'hE0, 32'hD3C2B1A0};
      @(posedge clk_i);
      rvalid <= 1'h0;
      repeat (SLOW + 10) @(posedge clk_i);
      n0 = ncmd;
      send(32'h0);
      check(ncmd, n0);
      apb(1'h0, `FHP_A_UL0, 32'h0);
      check(rd & 32'hFFFF_FFDF, {rows[i].p, rows[i].st[7:0], rows[i].st[15:8]});
      apb(1'h0, `FHP_A_UL1, 32'h0);
      check(rd, {rows[i].p ^ 16'h0F0F, ~rows[i].p});
      apb(1'h0, `FHP_A_UL2, 32'h0);
      check(rd, 32'hD3C2B1A0);
      apb(1'h0, `FHP_A_UL3, 32'h0);
      check(rd, 32'h0000_08E0);
      $display("row %0d done", i);
    end
    flags <= 9'h000;
    repeat (60) @(posedge clk_i);
    send(32'h0);
    apb(1'h0, `FHP_A_UL0, 32'h0);
    check(rd[15], 1'h0);
    $display("fast refresh test done");
    apb(1'h1, `FHP_A_INT_EN, 32'h1);
    send(32'h0);
    repeat (2) @(posedge clk_i);
    check(irq, 1'h1);
    apb(1'h1, `FHP_A_INT_CLR, 32'h1);
    repeat (2) @(posedge clk_i);
    check(irq, 1'h0);
    apb(1'h1, `FHP_A_INT_EN, 32'h0);
    send(32'h0);
    check(irq, 1'h0);
    apb(1'h0, 8'h40, 32'h0);
    check(err, 1'h1);
    $display("irq test done");
    @(posedge clk_i);
    phy_err <= 1'h1;
    @(posedge clk_i);
    phy_err <= 1'h0;
    repeat (2) @(posedge clk_i);
    check({fault, rf_en}, 2'h2);
    apb(1'h0, `FHP_A_STAT, 32'h0);
    check(rd[1], 1'h1);
    check(rd[2], 1'h0);
    apb(1'h0, `FHP_A_INT_ST, 32'h0);
    check(rd[2], 1'h1);
    send(32'h0000_0008);
    check(fault, 1'h1);
    n0 = ncmd;
    send(32'h0000_0077);
    check({fault, rf_en, 8'(ncmd - n0)}, 10'h100);
    $display("fault test done");
    apb(1'h1, `FHP_A_INT_EN, 32'h4);
    @(posedge clk_i);
    phy_err <= 1'h1;
    @(posedge clk_i);
    phy_err <= 1'h0;
    rstn_i <= 1'h0;
    repeat (5) @(posedge clk_i);
    check({fault, rf_en, irq}, 3'h2);
    rstn_i <= 1'h1;
    apb(1'h0, `FHP_A_INT_EN, 32'h0);
    check(rd, 32'h0);
    $display("reset test done");
    give_verdict();
  end
endmodule
`default_nettype wire
